/* include/tmc_pkg.sv */
`default_nettype none
package tmc_pkg;
    // apb byte address is four times the register index
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned IDX_W  = 10;

    // register indices
    localparam logic [9:0] IDX_RUN_FLAG   = 10'h088;
    localparam logic [9:0] IDX_MODE       = 10'h089;
    localparam logic [9:0] IDX_T0_LOW     = 10'h08a;
    localparam logic [9:0] IDX_T1_LOW     = 10'h08b;
    localparam logic [9:0] IDX_T0_HIGH    = 10'h08c;
    localparam logic [9:0] IDX_T1_HIGH    = 10'h08d;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h0a0;
    localparam logic [9:0] IDX_IRQ_ENABLE = 10'h0a1;
    localparam logic [9:0] IDX_IRQ_CLEAR  = 10'h0a2;

    // timer_mode_control fields
    localparam int unsigned MODE_GATE1 = 7;
    localparam int unsigned MODE_SRC1  = 6;
    localparam int unsigned MODE_SEL1  = 4;
    localparam int unsigned MODE_GATE0 = 3;
    localparam int unsigned MODE_SRC0  = 2;
    localparam int unsigned MODE_SEL0  = 0;

    // timer_run_flag_register fields
    localparam int unsigned RF_OVF1 = 7;
    localparam int unsigned RF_RUN1 = 6;
    localparam int unsigned RF_OVF0 = 5;
    localparam int unsigned RF_RUN0 = 4;

    // interrupt status/enable/clear fields
    localparam int unsigned IRQ_W    = 2;
    localparam int unsigned IRQ_OVF0 = 0;
    localparam int unsigned IRQ_OVF1 = 1;

    // mode field codes
    localparam logic [1:0] MODE_PRESCALE = 2'h0;
    localparam logic [1:0] MODE_WIDE     = 2'h1;
    localparam logic [1:0] MODE_RELOAD   = 2'h2;
    localparam logic [1:0] MODE_SPLIT    = 2'h3;

    // reset values
    localparam logic [7:0] MODE_RST  = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;

    // internal count tick: one pclk-enable pulse every TICK_DIV cycles
    localparam logic [3:0] TICK_DIV = 4'hc;
endpackage
`default_nettype wire

/* hdl/tmc_pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module tmc_pin_sync
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin_async,
    output logic      pin_level,
    output logic      pin_fall
);
    import tmc_pkg::*;

    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } tmc_sync_type;

    tmc_sync_type sync_r;
    tmc_sync_type sync_nxt;

    // two-stage synchroniser plus one stage of history
    always_comb
    begin
        sync_nxt      = sync_r;
        sync_nxt.meta = pin_async;
        sync_nxt.sync = sync_r.meta;
        sync_nxt.prev = sync_r.sync;
    end

    // idle high so release from reset makes no false edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sync_r <= '1;
        else
            sync_r <= sync_nxt;
    end

    assign pin_level = sync_r.sync;
    // R13: high then low sample
    assign pin_fall  = sync_r.prev & ~sync_r.sync;
endmodule
`default_nettype wire

/* hdl/tmc_irq_ctl.sv */
`timescale 1ns/10ps
`default_nettype none
module tmc_irq_ctl
(
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic [tmc_pkg::IRQ_W-1:0] event_pulse,
    input  wire logic                      enable_we,
    input  wire logic [tmc_pkg::IRQ_W-1:0] enable_wdata,
    input  wire logic                      clear_we,
    input  wire logic [tmc_pkg::IRQ_W-1:0] clear_wdata,
    output logic      [tmc_pkg::IRQ_W-1:0] status,
    output logic      [tmc_pkg::IRQ_W-1:0] enable,
    output logic                           irq
);
    import tmc_pkg::*;

    typedef struct packed {
        logic [IRQ_W-1:0] status;
        logic [IRQ_W-1:0] enable;
    } tmc_irq_type;

    tmc_irq_type irq_r;
    tmc_irq_type irq_nxt;

    // write-one-to-clear; a new event in the same cycle wins
    always_comb
    begin
        irq_nxt = irq_r;
        if (clear_we)
            irq_nxt.status = irq_r.status & ~clear_wdata;
        irq_nxt.status = irq_nxt.status | event_pulse;
        if (enable_we)
            irq_nxt.enable = enable_wdata;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_r <= '0;
        else
            irq_r <= irq_nxt;
    end

    assign status = irq_r.status;
    assign enable = irq_r.enable;
    // level output, drops once every enabled bit is cleared
    assign irq    = |(irq_r.status & irq_r.enable);
endmodule
`default_nettype wire

/* hdl/tmc_timer_top.sv */
// What this block does
// R1: with qualify bit set, timer counts only while irq pin high and run set.
// R2: with qualify bit clear, the irq pin is ignored; run bit alone enables.
// R3: source bit clear counts internal ticks, set counts count-pin falling edges.
// R4: mode bits 5:4 serve timer 1, bits 1:0 serve timer 0, modes 0-3.
// R5: mode 0 uses low byte as 5-bit prescaler into 8-bit high byte.
// R6: mode 1 joins high and low bytes into one 16-bit counter.
// R7: mode 2 counts low byte, reloading it from high byte on overflow.
// R8: mode 3 splits timer 0; high byte ticks under timer 1 run bit.
// R9: timer 1 in mode 3 stops and holds its count.
// R10: count bytes are software registers at indices 8a, 8b, 8c, 8d.
// R11: overflow sets flag; service entry clears it; software may set or clear.
// R12: software run bit switches each timer on or off, combined with qualify.
// R13: count pins are synchronised; one increment per high-then-low sample pair.
`timescale 1ns/10ps
`default_nettype none
module tmc_timer_top
(
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [tmc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       count_input_pin_zero,
    input  wire logic                       count_input_pin_one,
    input  wire logic                       ext_irq_pin_zero_n,
    input  wire logic                       ext_irq_pin_one_n,
    input  wire logic                       ovf_ack_zero,
    input  wire logic                       ovf_ack_one,
    output logic                            timer0_overflow_flag,
    output logic                            timer1_overflow_flag,
    output logic                            irq
);
    import tmc_pkg::*;

    typedef struct packed {
        logic [7:0]  mode;
        logic [7:0]  t0_low;
        logic [7:0]  t0_high;
        logic [7:0]  t1_low;
        logic [7:0]  t1_high;
        logic        run0;
        logic        run1;
        logic        ovf0;
        logic        ovf1;
        logic [3:0]  tick_cnt;
        logic        tick;
        logic [31:0] rdata;
    } tmc_state_type;

    tmc_state_type state_r;
    tmc_state_type state_nxt;

    logic             t0_level;
    logic             t0_fall;
    logic             t1_level;
    logic             t1_fall;
    logic             gate0_level;
    logic             gate1_level;
    logic [IDX_W-1:0] idx;
    logic             mapped;
    logic             setup;
    logic             wr;
    logic [1:0]       sel0;
    logic [1:0]       sel1;
    logic             split0;
    logic             en0;
    logic             en1;
    logic             inc0;
    logic             inc1;
    logic             inc_t0_high;
    logic [16:0]      step0;
    logic [16:0]      step1;
    logic [8:0]       t0_high_sum;
    logic             ovf0_evt;
    logic             ovf1_evt;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic [IRQ_W-1:0] irq_events;

    // one counting step: returns {overflow, high, low}
    function automatic logic [16:0] tmc_step
    (
        input logic [1:0] mode,
        input logic [7:0] low,
        input logic [7:0] high,
        input logic       inc
    );
        logic [16:0] res;
        logic [8:0]  sum;
        res = {1'b0, high, low};
        sum = 9'h000;
        if (inc)
        begin
            unique case (mode)
                // R5: 5-bit prescale feeds 8-bit high byte
                MODE_PRESCALE:
                begin
                    if (low[4:0] == 5'h1f)
                    begin
                        sum = {1'b0, high} + 9'h001;
                        res = {sum[8], sum[7:0], low[7:5], 5'h00};
                    end
                    else
                        res = {1'b0, high, low[7:5], low[4:0] + 5'h01};
                end
                // R6: full 16-bit count
                MODE_WIDE:
                    res = {1'b0, high, low} + 17'h00001;
                // R7: reload low from high on overflow
                MODE_RELOAD:
                begin
                    if (low == 8'hff)
                        res = {1'b1, high, high};
                    else
                        res = {1'b0, high, low + 8'h01};
                end
                // R8: low byte alone as 8-bit counter
                MODE_SPLIT:
                begin
                    sum = {1'b0, low} + 9'h001;
                    res = {sum[8], high, sum[7:0]};
                end
            endcase
        end
        return res;
    endfunction

    // R13: count pins through synchroniser and edge detect
    tmc_pin_sync u_sync_t0
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_async (count_input_pin_zero),
        .pin_level (t0_level),
        .pin_fall  (t0_fall)
    );

    tmc_pin_sync u_sync_t1
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_async (count_input_pin_one),
        .pin_level (t1_level),
        .pin_fall  (t1_fall)
    );

    // gate pins only need the level, edges unused
    tmc_pin_sync u_sync_g0
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_async (ext_irq_pin_zero_n),
        .pin_level (gate0_level),
        .pin_fall  ()
    );

    tmc_pin_sync u_sync_g1
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_async (ext_irq_pin_one_n),
        .pin_level (gate1_level),
        .pin_fall  ()
    );

    // apb decode; zero wait states, so access completes at once
    assign idx    = paddr[ADDR_W-1:2];
    assign mapped = (paddr[1:0] == 2'h0) &&
                    ((idx >= IDX_RUN_FLAG && idx <= IDX_T1_HIGH) ||
                     (idx >= IDX_IRQ_STATUS && idx <= IDX_IRQ_CLEAR));
    assign setup  = psel & ~penable;
    assign wr     = psel & penable & pwrite & mapped;

    // R4: mode field decode per timer
    assign sel0   = state_r.mode[MODE_SEL0 +: 2];
    assign sel1   = state_r.mode[MODE_SEL1 +: 2];
    assign split0 = (sel0 == MODE_SPLIT);

    // R1: qualify bit makes the irq pin a count gate
    // R2: clear qualify bit leaves run bit alone
    // R12: run bit and gate form the count enable
    assign en0 = state_r.run0 & (~state_r.mode[MODE_GATE0] | gate0_level);
    assign en1 = state_r.run1 & (~state_r.mode[MODE_GATE1] | gate1_level);

    // R3: internal tick or count-pin falling edge
    assign inc0 = en0 & (state_r.mode[MODE_SRC0] ? t0_fall : state_r.tick);
    // R9: timer 1 frozen in mode 3
    assign inc1 = en1 & (sel1 != MODE_SPLIT) &
                  (state_r.mode[MODE_SRC1] ? t1_fall : state_r.tick);

    // R8: split high byte runs on internal ticks under timer 1 run bit
    assign inc_t0_high = split0 & state_r.run1 & state_r.tick;
    assign t0_high_sum = {1'b0, state_r.t0_high} + 9'h001;

    assign step0 = tmc_step(sel0, state_r.t0_low, state_r.t0_high, inc0);
    assign step1 = tmc_step(sel1, state_r.t1_low, state_r.t1_high, inc1);

    // while timer 0 is split its high byte owns the timer 1 flag
    assign ovf0_evt = step0[16];
    assign ovf1_evt = split0 ? (inc_t0_high & t0_high_sum[8]) : step1[16];

    // next state: divider, counting, software writes, read capture
    always_comb
    begin
        state_nxt      = state_r;
        state_nxt.tick = 1'b0;
        if (state_r.tick_cnt == TICK_DIV - 4'h1)
        begin
            state_nxt.tick_cnt = 4'h0;
            state_nxt.tick     = 1'b1;
        end
        else
            state_nxt.tick_cnt = state_r.tick_cnt + 4'h1;

        state_nxt.t0_low  = step0[7:0];
        state_nxt.t0_high = split0 ? (inc_t0_high ? t0_high_sum[7:0] : state_r.t0_high)
                                   : step0[15:8];
        state_nxt.t1_low  = step1[7:0];
        state_nxt.t1_high = step1[15:8];

        // R10: software writes override a count in the same cycle
        if (wr)
        begin
            unique case (idx)
                IDX_MODE:    state_nxt.mode    = pwdata[7:0];
                IDX_T0_LOW:  state_nxt.t0_low  = pwdata[7:0];
                IDX_T1_LOW:  state_nxt.t1_low  = pwdata[7:0];
                IDX_T0_HIGH: state_nxt.t0_high = pwdata[7:0];
                IDX_T1_HIGH: state_nxt.t1_high = pwdata[7:0];
                IDX_RUN_FLAG:
                begin
                    state_nxt.run0 = pwdata[RF_RUN0];
                    state_nxt.run1 = pwdata[RF_RUN1];
                    state_nxt.ovf0 = pwdata[RF_OVF0];
                    state_nxt.ovf1 = pwdata[RF_OVF1];
                end
                default:
                begin
                end
            endcase
        end

        // R11: service entry clears, overflow sets and wins
        if (ovf_ack_zero)
            state_nxt.ovf0 = 1'b0;
        if (ovf_ack_one)
            state_nxt.ovf1 = 1'b0;
        state_nxt.ovf0 = state_nxt.ovf0 | ovf0_evt;
        state_nxt.ovf1 = state_nxt.ovf1 | ovf1_evt;

        // read data is caught in the setup phase, held through access
        if (setup)
        begin
            state_nxt.rdata = 32'h0000_0000;
            if (!pwrite && mapped)
            begin
                unique case (idx)
                    IDX_MODE:    state_nxt.rdata[7:0] = state_r.mode;
                    IDX_T0_LOW:  state_nxt.rdata[7:0] = state_r.t0_low;
                    IDX_T1_LOW:  state_nxt.rdata[7:0] = state_r.t1_low;
                    IDX_T0_HIGH: state_nxt.rdata[7:0] = state_r.t0_high;
                    IDX_T1_HIGH: state_nxt.rdata[7:0] = state_r.t1_high;
                    IDX_RUN_FLAG:
                    begin
                        state_nxt.rdata[RF_RUN0] = state_r.run0;
                        state_nxt.rdata[RF_RUN1] = state_r.run1;
                        state_nxt.rdata[RF_OVF0] = state_r.ovf0;
                        state_nxt.rdata[RF_OVF1] = state_r.ovf1;
                    end
                    IDX_IRQ_STATUS: state_nxt.rdata[IRQ_W-1:0] = irq_status;
                    IDX_IRQ_ENABLE: state_nxt.rdata[IRQ_W-1:0] = irq_enable;
                    default:
                    begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r          <= '0;
            state_r.mode     <= MODE_RST;
            state_r.t0_low   <= COUNT_RST;
            state_r.t0_high  <= COUNT_RST;
            state_r.t1_low   <= COUNT_RST;
            state_r.t1_high  <= COUNT_RST;
        end
        else
            state_r <= state_nxt;
    end

    // overflow events into sticky status and the irq line
    assign irq_events[IRQ_OVF0] = ovf0_evt;
    assign irq_events[IRQ_OVF1] = ovf1_evt;

    tmc_irq_ctl u_irq
    (
        .pclk         (pclk),
        .presetn      (presetn),
        .event_pulse  (irq_events),
        .enable_we    (wr && idx == IDX_IRQ_ENABLE),
        .enable_wdata (pwdata[IRQ_W-1:0]),
        .clear_we     (wr && idx == IDX_IRQ_CLEAR),
        .clear_wdata  (pwdata[IRQ_W-1:0]),
        .status       (irq_status),
        .enable       (irq_enable),
        .irq          (irq)
    );

    assign prdata               = state_r.rdata;
    assign pready               = 1'b1;
    assign pslverr              = psel & penable & ~mapped;
    assign timer0_overflow_flag = state_r.ovf0;
    assign timer1_overflow_flag = state_r.ovf1;
endmodule
`default_nettype wire

/* testbench/tmc_timer_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module tmc_timer_asserts
(
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [tmc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       ovf_ack_zero,
    input wire logic                       timer0_overflow_flag,
    input wire logic                       timer1_overflow_flag,
    input wire logic                       irq
);
    import tmc_pkg::*;
    localparam logic [11:0] A_RF = {IDX_RUN_FLAG, 2'b00};
    localparam logic [11:0] A_MD = {IDX_MODE, 2'b00};
    localparam logic [11:0] A_0L = {IDX_T0_LOW, 2'b00};
    logic acc;
    logic wr;
    logic rf_wr;
    // access-phase qualifiers shared by the properties
    assign acc   = psel && penable;
    assign wr    = acc && pwrite;
    assign rf_wr = wr && (paddr == A_RF);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    pready_hi_a: assert property (acc |-> pready)
        else $error("pready low in access");
    bad_addr_a: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    good_addr_a: assert property (acc && paddr == A_0L |-> !pslverr)
        else $error("count byte access refused");
    rd_upper_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    mode_rb_a: assert property ((wr && paddr == A_MD) ##1 !psel ##1 (psel && !penable && !pwrite && paddr == A_MD) |=> prdata[7:0] == $past(pwdata[7:0], 3))
        else $error("mode register readback differs");
    flag0_set_a: assert property (rf_wr && pwdata[5] |=> timer0_overflow_flag)
        else $error("timer0 flag not set by software");
    flag1_set_a: assert property (rf_wr && pwdata[7] |=> timer1_overflow_flag)
        else $error("timer1 flag not set by software");
    // flag clears only by service or software
    flag_fall_a: assert property ($fell(timer0_overflow_flag) |-> $past(ovf_ack_zero) || $past(rf_wr))
        else $error("timer0 flag cleared without cause");
    // irq drops only on register write
    irq_fall_a: assert property ($fell(irq) |-> $past(wr))
        else $error("irq dropped without write");
endmodule

bind tmc_timer_top tmc_timer_asserts u_chk
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ovf_ack_zero(ovf_ack_zero),
    .timer0_overflow_flag(timer0_overflow_flag),
    .timer1_overflow_flag(timer1_overflow_flag), .irq(irq)
);
`default_nettype wire

/* testbench/tmc_pin_model.sv */
`timescale 1ns/10ps
`default_nettype none
module tmc_pin_model
(
    input  wire logic pclk,
    output logic      count_input_pin_zero,
    output logic      count_input_pin_one,
    output logic      ext_irq_pin_zero_n,
    output logic      ext_irq_pin_one_n
);
    // pins rest high so no false edge shows at reset release
    initial
    begin
        count_input_pin_zero = 1'b1;
        count_input_pin_one  = 1'b1;
        ext_irq_pin_zero_n   = 1'b1;
        ext_irq_pin_one_n    = 1'b1;
    end

    // each level held 4 cycles, longer than the two-flop sampling window
    task automatic fall(input logic [1:0] m, input int n);
        repeat (n)
        begin
            @(posedge pclk);
            count_input_pin_zero <= !m[0];
            count_input_pin_one  <= !m[1];
            repeat (4) @(posedge pclk);
            count_input_pin_zero <= 1'b1;
            count_input_pin_one  <= 1'b1;
            repeat (4) @(posedge pclk);
        end
    endtask

    // gate levels need two flops to reach the counter
    task automatic gate(input logic g0, input logic g1);
        @(posedge pclk);
        ext_irq_pin_zero_n <= g0;
        ext_irq_pin_one_n  <= g1;
        repeat (3) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
    import tmc_pkg::*;
    localparam logic [11:0] A_RF = {IDX_RUN_FLAG, 2'b00};
    localparam logic [11:0] A_MD = {IDX_MODE, 2'b00};
    localparam logic [11:0] A_0L = {IDX_T0_LOW, 2'b00};
    localparam logic [11:0] A_1L = {IDX_T1_LOW, 2'b00};
    localparam logic [11:0] A_0H = {IDX_T0_HIGH, 2'b00};
    localparam logic [11:0] A_1H = {IDX_T1_HIGH, 2'b00};
    localparam logic [11:0] A_ST = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [11:0] A_EN = {IDX_IRQ_ENABLE, 2'b00};
    localparam logic [11:0] A_CL = {IDX_IRQ_CLEAR, 2'b00};
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cnt0;
    logic        cnt1;
    logic        gate0_n;
    logic        gate1_n;
    logic        ack0;
    logic        ack1;
    logic        flag0;
    logic        flag1;
    logic        irq;
    logic [31:0] q;
    logic        e;
    int          err_total;
    int          checks_done;

    tmc_timer_top u_dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .count_input_pin_zero(cnt0), .count_input_pin_one(cnt1),
        .ext_irq_pin_zero_n(gate0_n), .ext_irq_pin_one_n(gate1_n),
        .ovf_ack_zero(ack0), .ovf_ack_one(ack1), .timer0_overflow_flag(flag0),
        .timer1_overflow_flag(flag1), .irq(irq)
    );

    tmc_pin_model u_pins
    (
        .pclk(pclk), .count_input_pin_zero(cnt0), .count_input_pin_one(cnt1),
        .ext_irq_pin_zero_n(gate0_n), .ext_irq_pin_one_n(gate1_n)
    );

    // 250 mhz core clock
    always #2 pclk = ~pclk;

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one apb transfer; ends at the falling edge so flags have settled
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rc(input logic [11:0] a, input logic [31:0] x, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, q, x);
    endtask

    task automatic t_regs();
        logic [11:0] ra [5];
        ra = '{A_MD, A_0L, A_1L, A_0H, A_1H};
        foreach (ra[i])
        begin
            rc(ra[i], 32'h0, "reset");
            wr(ra[i], 32'h5a + 32'(i));
            rc(ra[i], 32'h5a + 32'(i), "readback");
        end
        rc(12'hffc, 32'h0, "unmapped");
        chk("unmapped_err", 32'(e), 32'h1);
        wr(A_0L + 12'h1, 32'hff);
        chk("misalign_err", 32'(e), 32'h1);
        rc(A_0L, 32'h5b, "misalign_keep");
        wr(A_MD, 32'h0);
    endtask

    task automatic t_reload();
        wr(A_MD, 32'h06);
        wr(A_0L, 32'hfd);
        wr(A_0H, 32'h80);
        wr(A_EN, 32'h1);
        wr(A_RF, 32'h10);
        u_pins.fall(2'h1, 2);
        rc(A_0L, 32'hff, "pin_count");
        chk("no_ovf", 32'(flag0), 32'h0);
        u_pins.fall(2'h1, 1);
        rc(A_0L, 32'h80, "reload");
        chk("ovf0", 32'(flag0), 32'h1);
        chk("irq_on", 32'(irq), 32'h1);
        rc(A_ST, 32'h1, "status");
        wr(A_CL, 32'h1);
        chk("irq_clr", 32'(irq), 32'h0);
        wr(A_EN, 32'h0);
        wr(A_0L, 32'hff);
        u_pins.fall(2'h1, 1);
        chk("irq_mask", 32'(irq), 32'h0);
        wr(A_EN, 32'h1);
        chk("irq_unmask", 32'(irq), 32'h1);
        wr(A_CL, 32'h1);
        wr(A_RF, 32'h0);
        u_pins.fall(2'h1, 1);
        rc(A_0L, 32'h80, "run_off");
        chk("sw_clear", 32'(flag0), 32'h0);
    endtask

    // rows: mode, low, high, expected low, expected high, expected flag
    task automatic t_count();
        logic [47:0] tab [5];
        tab = '{48'h05ff12001300, 48'h05ffff000001, 48'h04ff05e00600,
                48'h041fff000001, 48'h040e050f0500};
        foreach (tab[i])
        begin
            wr(A_RF, 32'h0);
            wr(A_MD, {24'h0, tab[i][47:40]});
            wr(A_0L, {24'h0, tab[i][39:32]});
            wr(A_0H, {24'h0, tab[i][31:24]});
            wr(A_RF, 32'h10);
            u_pins.fall(2'h1, 1);
            rc(A_0L, {24'h0, tab[i][23:16]}, "low");
            rc(A_0H, {24'h0, tab[i][15:8]}, "high");
            chk("ovf", 32'(flag0), {24'h0, tab[i][7:0]});
        end
    endtask

    task automatic t_gate();
        wr(A_RF, 32'h0);
        wr(A_MD, 32'hdd);
        wr(A_0L, 32'h0);
        wr(A_1L, 32'h0);
        wr(A_RF, 32'h50);
        u_pins.gate(1'b0, 1'b0);
        u_pins.fall(2'h3, 1);
        rc(A_0L, 32'h0, "gate0_shut");
        rc(A_1L, 32'h0, "gate1_shut");
        u_pins.gate(1'b1, 1'b1);
        u_pins.fall(2'h3, 1);
        rc(A_0L, 32'h1, "gate0_open");
        rc(A_1L, 32'h1, "gate1_open");
        u_pins.gate(1'b0, 1'b0);
        wr(A_MD, 32'h55);
        u_pins.fall(2'h3, 1);
        rc(A_0L, 32'h2, "gate0_off");
        rc(A_1L, 32'h2, "gate1_off");
        u_pins.gate(1'b1, 1'b1);
    endtask

    task automatic t_split();
        logic [31:0] v;
        wr(A_RF, 32'h0);
        wr(A_MD, 32'h37);
        wr(A_0L, 32'hff);
        wr(A_0H, 32'hff);
        wr(A_1L, 32'h40);
        wr(A_RF, 32'h50);
        u_pins.fall(2'h3, 1);
        chk("split_low", 32'(flag0), 32'h1);
        repeat (30) @(negedge pclk);
        chk("split_high", 32'(flag1), 32'h1);
        rc(A_1L, 32'h40, "t1_frozen");
        wr(A_RF, 32'h10);
        apb(1'b0, A_0H, 32'h0);
        v = q;
        repeat (30) @(negedge pclk);
        rc(A_0H, v, "high_run1_off");
    endtask

    task automatic t_ack();
        wr(A_MD, 32'h20);
        wr(A_1L, 32'hfe);
        wr(A_RF, 32'h40);
        repeat (30) @(negedge pclk);
        chk("tick_ovf1", 32'(flag1), 32'h1);
        wr(A_RF, 32'ha0);
        chk("sw_set0", 32'(flag0), 32'h1);
        chk("sw_set1", 32'(flag1), 32'h1);
        @(posedge pclk);
        ack0 <= 1'b1;
        ack1 <= 1'b1;
        @(posedge pclk);
        ack0 <= 1'b0;
        ack1 <= 1'b0;
        @(negedge pclk);
        chk("ack0", 32'(flag0), 32'h0);
        chk("ack1", 32'(flag1), 32'h0);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // main sequence after a 16 cycle reset
    initial
    begin
        pclk        = 1'b0;
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 12'h0;
        pwdata      = 32'h0;
        ack0        = 1'b0;
        ack1        = 1'b0;
        err_total   = 0;
        checks_done = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_reload();
        t_count();
        t_gate();
        t_split();
        t_ack();
        print_verdict();
    end

    // the run needs about five hundred cycles; ten times that means a hang
    initial
    begin
        repeat (5000) @(posedge pclk);
        err_total++;
        print_verdict();
    end
endmodule
`default_nettype wire
